// *** verilog/asps_sequencer.sv ***
`timescale 1ns/1ps
// What this block does
// R1 - Mode zero bypasses stepping, normal path rules
// R2 - Modes 1,4: one pass then stop
// R3 - Modes 2,5: loop stages forever
// R4 - Modes 3,6: one pass, hold last stage
// R5 - Modes 1-3: resume interrupted stage
// R6 - Modes 4-6: restart at stage 0
// R7 - Mode 2 restarts from stopped stage speed
// R8 - Stage 0 general freq, 1-15 dedicated
// R9 - Sixteen stage times, 0.0 to 6000.0 s
// R10 - Direction per stage: stop, forward, reverse
// R11 - Wobble or PID suppresses stepping
// R12 - Stepping disables external multi-step inputs
// R13 - Stepping uses primary accel/decel times
// R14 - All stage times zero: stepping inactive
// R15 - Modes 4-6 restart from stage 0 freq
// R16 - Stages ascend, each held until timer expires
// R17 - Stage 0 frequency limited to 599.00 Hz
module asps_sequencer #(
  parameter int unsigned TICK_CYCLES = asps_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] MODE,
  input wire logic RUN,
  input wire logic WOBBLE_ACTIVE,
  input wire logic PID_ACTIVE,
  input wire logic [15:0] STAGE0_FREQ,
  input wire logic [239:0] STAGE_FREQ,
  input wire logic [255:0] STAGE_TIME,
  input wire logic [31:0] STAGE_DIR,
  input wire logic [15:0] NORMAL_FREQ,
  input wire logic [1:0] NORMAL_DIR,
  input wire logic [15:0] PRIMARY_ACC_TIME,
  input wire logic [15:0] PRIMARY_DEC_TIME,
  input wire logic [15:0] NORMAL_ACC_TIME,
  input wire logic [15:0] NORMAL_DEC_TIME,
  output logic [15:0] FREQ_REF,
  output logic [1:0] DIR_CMD,
  output logic [15:0] ACC_TIME,
  output logic [15:0] DEC_TIME,
  output logic MULTI_STEP_EN,
  output logic AUTO_ACTIVE,
  output logic CYCLE_DONE,
  output logic [3:0] STAGE
);

  typedef struct packed {
    asps_pkg::asps_state_t fsm;
    logic [3:0] stage;
    logic paused;
    logic load;
    logic en;
    logic [15:0] duration;
    logic [15:0] freq;
    logic [1:0] dir;
    logic active;
    logic done;
    logic mstep_en;
    logic [15:0] acc;
    logic [15:0] dec;
  } asps_seq_t;

  asps_seq_t r;
  asps_seq_t next_r;
  logic en_ok;
  asps_tmr_if tbus ();

  // --------------------------------------------------------------------
  // Stage table lookup
  // --------------------------------------------------------------------
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // R8 stage 0 from general setting
  // R17 stage 0 limited like the others
  function automatic logic [15:0] freq_of(input logic [3:0] s);
    if (s == asps_pkg::FIRST_STAGE)
      return clamp(STAGE0_FREQ, asps_pkg::FREQ_MAX);
    return clamp(STAGE_FREQ[16 * (int'(s) - 1) +: 16], asps_pkg::FREQ_MAX);
  endfunction

  // R9 per-stage run time
  function automatic logic [15:0] time_of(input logic [3:0] s);
    return clamp(STAGE_TIME[16 * int'(s) +: 16], asps_pkg::TIME_MAX);
  endfunction

  // R10 undefined code 3 treated as stop
  function automatic logic [1:0] dir_of(input logic [3:0] s);
    logic [1:0] d;
    d = STAGE_DIR[2 * int'(s) +: 2];
    return (d == 2'b11) ? asps_pkg::DIR_STOP : d;
  endfunction

  // --------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------
  // R1 R11 R14 stepping allowed only under these
  assign en_ok = (MODE != asps_pkg::MODE_OFF) && (MODE <= asps_pkg::MODE_MAX)
               && !WOBBLE_ACTIVE && !PID_ACTIVE && (|STAGE_TIME);

  always_comb
  begin
    next_r = r;
    next_r.load = 1'b0;
    if (!en_ok)
    begin
      next_r.fsm = asps_pkg::ST_IDLE;
      next_r.stage = asps_pkg::FIRST_STAGE;
      next_r.paused = 1'b0;
      next_r.en = 1'b0;
    end
    else
    begin
      case (r.fsm)
        asps_pkg::ST_IDLE:
        begin
          next_r.en = 1'b0;
          // Expiry seen after stop: remainder lost, stage reloads whole
          if (tbus.expire)
            next_r.paused = 1'b0;
          if (RUN)
          begin
            next_r.fsm = asps_pkg::ST_RUN;
            next_r.en = 1'b1;
            next_r.paused = 1'b0;
            // R5 R7 resume keeps timer remainder
            if (!(asps_pkg::asps_resume(MODE) && r.paused && !tbus.expire))
            begin
              next_r.load = 1'b1;
              next_r.duration = time_of(r.stage);
            end
          end
        end
        asps_pkg::ST_RUN:
        begin
          if (!RUN)
          begin
            next_r.fsm = asps_pkg::ST_IDLE;
            next_r.en = 1'b0;
            next_r.paused = asps_pkg::asps_resume(MODE) && !tbus.expire;
            // R6 R15 reset modes go back to stage 0
            if (!asps_pkg::asps_resume(MODE))
              next_r.stage = asps_pkg::FIRST_STAGE;
          end
          else if (tbus.expire)
          begin
            // R16 ascend to next stage
            if (r.stage != asps_pkg::LAST_STAGE)
            begin
              next_r.stage = r.stage + 4'h1;
              next_r.load = 1'b1;
              next_r.duration = time_of(r.stage + 4'h1);
            end
            // R2 single pass ends in stop
            else if (asps_pkg::asps_single(MODE))
            begin
              next_r.fsm = asps_pkg::ST_DONE;
              next_r.en = 1'b0;
            end
            // R3 wrap to first stage
            else if (asps_pkg::asps_cont(MODE))
            begin
              next_r.stage = asps_pkg::FIRST_STAGE;
              next_r.load = 1'b1;
              next_r.duration = time_of(asps_pkg::FIRST_STAGE);
            end
            // R4 keep last stage running
            else
            begin
              next_r.fsm = asps_pkg::ST_HOLD;
              next_r.en = 1'b0;
            end
          end
        end
        default:
        begin
          if (!RUN)
          begin
            next_r.fsm = asps_pkg::ST_IDLE;
            next_r.stage = asps_pkg::FIRST_STAGE;
            next_r.paused = 1'b0;
          end
        end
      endcase
    end

    next_r.active = en_ok && (next_r.fsm != asps_pkg::ST_IDLE);
    next_r.done = en_ok && (next_r.fsm == asps_pkg::ST_DONE);
    // R1 disabled: normal reference passes through
    if (!en_ok)
    begin
      next_r.freq = NORMAL_FREQ;
      next_r.dir = NORMAL_DIR;
    end
    else
    begin
      next_r.freq = (next_r.fsm == asps_pkg::ST_DONE) ? 16'h0000 : freq_of(next_r.stage);
      next_r.dir = (next_r.fsm == asps_pkg::ST_RUN || next_r.fsm == asps_pkg::ST_HOLD)
        ? dir_of(next_r.stage) : asps_pkg::DIR_STOP;
    end
    // R12 multi-step inputs blocked
    next_r.mstep_en = !next_r.active;
    // R13 primary ramp times only
    next_r.acc = next_r.active ? PRIMARY_ACC_TIME : NORMAL_ACC_TIME;
    next_r.dec = next_r.active ? PRIMARY_DEC_TIME : NORMAL_DEC_TIME;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      r <= '0;
      r.mstep_en <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign tbus.load = r.load;
  assign tbus.en = r.en;
  assign tbus.duration = r.duration;

  asps_stage_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(tbus)
  );

  assign FREQ_REF = r.freq;
  assign DIR_CMD = r.dir;
  assign ACC_TIME = r.acc;
  assign DEC_TIME = r.dec;
  assign MULTI_STEP_EN = r.mstep_en;
  assign AUTO_ACTIVE = r.active;
  assign CYCLE_DONE = r.done;
  assign STAGE = r.stage;
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_stage_end;
    r.fsm == asps_pkg::ST_RUN && RUN && en_ok && tbus.expire;
  endsequence
  sequence s_stop;
    r.fsm == asps_pkg::ST_RUN && !RUN && en_ok;
  endsequence
  property p_bypass;
    MODE == asps_pkg::MODE_OFF |=> FREQ_REF == $past(NORMAL_FREQ) && !AUTO_ACTIVE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass broken"); // R1
  property p_single_stop;
    s_stage_end ##0 (r.stage == asps_pkg::LAST_STAGE && asps_pkg::asps_single(MODE))
      |=> DIR_CMD == asps_pkg::DIR_STOP && CYCLE_DONE;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("no stop after pass"); // R2
  property p_wrap;
    s_stage_end ##0 (r.stage == asps_pkg::LAST_STAGE && asps_pkg::asps_cont(MODE))
      |=> STAGE == asps_pkg::FIRST_STAGE && tbus.load;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // R3
  property p_hold;
    s_stage_end ##0 (r.stage == asps_pkg::LAST_STAGE && !asps_pkg::asps_cont(MODE)
      && !asps_pkg::asps_single(MODE)) |=> AUTO_ACTIVE && STAGE == asps_pkg::LAST_STAGE;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold"); // R4
  property p_resume;
    s_stop ##0 asps_pkg::asps_resume(MODE) && !tbus.expire |=> STAGE == $past(STAGE) && r.paused;
  endproperty
  a_resume: assert property (p_resume) else $error("stage lost"); // R5
  property p_restart;
    s_stop ##0 !asps_pkg::asps_resume(MODE) |=> STAGE == asps_pkg::FIRST_STAGE;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // R6
  property p_suppress;
    WOBBLE_ACTIVE || PID_ACTIVE || STAGE_TIME == '0 |=> !AUTO_ACTIVE;
  endproperty
  a_suppress: assert property (p_suppress) else $error("not suppressed"); // R11
  property p_mstep;
    AUTO_ACTIVE |-> !MULTI_STEP_EN;
  endproperty
  a_mstep: assert property (p_mstep) else $error("multi-step open"); // R12
  property p_ramp;
    AUTO_ACTIVE |-> ACC_TIME == $past(PRIMARY_ACC_TIME) && DEC_TIME == $past(PRIMARY_DEC_TIME);
  endproperty
  a_ramp: assert property (p_ramp) else $error("wrong ramp time"); // R13
  property p_ascend;
    s_stage_end ##0 r.stage != asps_pkg::LAST_STAGE |=> STAGE == $past(STAGE) + 4'h1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("stage skipped"); // R16
  property p_fmax;
    FREQ_REF <= asps_pkg::FREQ_MAX || !AUTO_ACTIVE;
  endproperty
  a_fmax: assert property (p_fmax) else $error("freq over limit"); // R17
endmodule

// *** verilog/asps_pkg.sv ***
package asps_pkg;

  // --------------------------------------------------------------------
  // Program mode selector
  // --------------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_MAX = 3'h6;
  localparam logic [2:0] MODE_SINGLE_RESUME = 3'h1;
  localparam logic [2:0] MODE_CONT_RESUME = 3'h2;
  localparam logic [2:0] MODE_HOLD_RESUME = 3'h3;
  localparam logic [2:0] MODE_SINGLE_RESET = 3'h4;
  localparam logic [2:0] MODE_CONT_RESET = 3'h5;
  localparam logic [2:0] MODE_HOLD_RESET = 3'h6;

  // --------------------------------------------------------------------
  // Stage program layout
  // --------------------------------------------------------------------
  localparam int STAGES = 16;
  localparam int VAL_W = 16;
  localparam logic [3:0] FIRST_STAGE = 4'h0;
  localparam logic [3:0] LAST_STAGE = 4'hF;
  // Frequency in 0.01 Hz, 599.00 Hz top
  localparam logic [15:0] FREQ_MAX = 16'hE9FC;
  // Stage time in 0.1 s, 6000.0 s top
  localparam logic [15:0] TIME_MAX = 16'hEA60;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIME_UNIT_NS = 100_000_000;
  localparam int TICK_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DIR_STOP = 2'b00,
    DIR_FWD = 2'b01,
    DIR_REV = 2'b10
  } asps_dir_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_DONE = 2'b11
  } asps_state_t;

  function automatic logic asps_resume(input logic [2:0] mode);
    return (mode >= MODE_SINGLE_RESUME) && (mode <= MODE_HOLD_RESUME);
  endfunction

  function automatic logic asps_single(input logic [2:0] mode);
    return (mode == MODE_SINGLE_RESUME) || (mode == MODE_SINGLE_RESET);
  endfunction

  function automatic logic asps_cont(input logic [2:0] mode);
    return (mode == MODE_CONT_RESUME) || (mode == MODE_CONT_RESET);
  endfunction

endpackage

// *** verilog/asps_tmr_if.sv ***
`timescale 1ns/1ps
interface asps_tmr_if;
  logic load;
  logic en;
  logic [15:0] duration;
  logic expire;
  modport seq (output load, output en, output duration, input expire);
  modport tmr (input load, input en, input duration, output expire);
endinterface

// *** verilog/asps_stage_timer.sv ***
`timescale 1ns/1ps
module asps_stage_timer #(
  parameter int unsigned TICK_CYCLES = asps_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  asps_tmr_if.tmr bus
);

  typedef struct packed {
    logic armed;
    logic [15:0] count;
    logic [31:0] div;
    logic expire;
  } asps_tmr_t;

  asps_tmr_t r;
  asps_tmr_t next_r;

  // Counting freezes while en is low, so a stopped stage keeps its remainder
  always_comb
  begin
    next_r = r;
    next_r.expire = 1'b0;
    if (bus.load)
    begin
      next_r.armed = 1'b1;
      next_r.count = bus.duration;
      next_r.div = 32'h0000_0000;
    end
    else if (r.armed && bus.en)
    begin
      if (r.count == 16'h0000)
      begin
        next_r.armed = 1'b0;
        next_r.expire = 1'b1;
      end
      else if (r.div == 32'(TICK_CYCLES - 1))
      begin
        next_r.div = 32'h0000_0000;
        next_r.count = r.count - 16'h0001;
      end
      else
      begin
        next_r.div = r.div + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign bus.expire = r.expire;

endmodule

// *** testbench/asps_ramp_model.sv ***
`timescale 1ns/1ps
module asps_ramp_model #(
  parameter int unsigned STEP = 32'h0000_0100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] freq_ref,
  input wire logic [1:0] dir_cmd,
  input wire logic [15:0] acc_time,
  input wire logic [15:0] dec_time,
  output logic [15:0] speed
);
  logic [15:0] target;
  // Stop drives the target to zero
  assign target = (dir_cmd == 2'h0) ? 16'h0000 : freq_ref;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      speed <= 16'h0000;
    else if (acc_time == 16'h0000 || dec_time == 16'h0000)
      speed <= target;
    else if (speed + STEP < target)
      speed <= speed + 16'(STEP);
    else if (speed > target + STEP)
      speed <= speed - 16'(STEP);
    else
      speed <= target;
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [2:0] m; logic w; logic p; logic z; logic a;} asps_row_t;
  logic clk, rst_n, run, wob, pid, msen, auto, done;
  logic [2:0] mode;
  logic [15:0] s0f, nfreq, fref, acc, dec, spd, nacc;
  logic [239:0] sf;
  logic [255:0] st, st_keep;
  logic [31:0] sd;
  logic [1:0] dir, ndir;
  logic [3:0] stg;
  int fail_count, checks_done, cyc;
  asps_row_t rows [6];

  asps_sequencer #(.TICK_CYCLES(4)) u_dut (.CLK(clk), .RST_N(rst_n), .MODE(mode),
    .RUN(run), .WOBBLE_ACTIVE(wob), .PID_ACTIVE(pid), .STAGE0_FREQ(s0f),
    .STAGE_FREQ(sf), .STAGE_TIME(st), .STAGE_DIR(sd), .NORMAL_FREQ(nfreq),
    .NORMAL_DIR(ndir), .PRIMARY_ACC_TIME(16'h0011), .PRIMARY_DEC_TIME(16'h0022),
    .NORMAL_ACC_TIME(nacc), .NORMAL_DEC_TIME(16'h0044), .FREQ_REF(fref),
    .DIR_CMD(dir), .ACC_TIME(acc), .DEC_TIME(dec), .MULTI_STEP_EN(msen),
    .AUTO_ACTIVE(auto), .CYCLE_DONE(done), .STAGE(stg));
  asps_ramp_model u_ramp (.clk(clk), .rst_n(rst_n), .freq_ref(fref), .dir_cmd(dir),
    .acc_time(acc), .dec_time(dec), .speed(spd));

  function automatic logic [15:0] fq(int n);
    return 16'h0050 + 16'(n) * 16'h0100;
  endfunction
  function automatic logic [1:0] dr(int n);
    return 2'((n + 1) % 3);
  endfunction
  function automatic logic [15:0] tm(int n);
    return 16'((n % 2) + 1);
  endfunction

  // --------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_stage(logic [3:0] s, output int c);
    c = 0;
    while (stg !== s)
    begin
      @(negedge clk);
      c++;
      if (c > 200)
      begin
        fail_count++;
        report_and_stop;
      end
    end
  endtask
  task automatic idle;
    run = 1'b0;
    mode = 3'h0;
    repeat (3) @(negedge clk);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic run_pass(logic [2:0] m);
    mode = m;
    run = 1'b1;
    repeat (2) @(negedge clk);
    for (int n = 0; n < 16; n++)
    begin
      wait_stage(n[3:0], cyc);
      if (n > 0) chk("time", 16'(cyc >= 4 * tm(n - 1) && cyc <= 4 * tm(n - 1) + 5), 16'h0001);
      chk("freq", fref, fq(n));
      chk("dir", dir, 16'(dr(n)));
      chk("acc", acc, 16'h0011);
      chk("dec", dec, 16'h0022);
      chk("msel", 16'(msen), 16'h0000);
    end
    repeat (40) @(negedge clk);
    if (m == 3'h1 || m == 3'h4)
    begin
      chk("done", 16'(done), 16'h0001);
      chk("stopdir", 16'(dir), 16'h0000);
      chk("stopfreq", fref, 16'h0000);
      chk("stopspeed", spd, 16'h0000);
    end
    else
    begin
      chk("holddir", 16'(dir), 16'(dr(15)));
      chk("holdfreq", fref, fq(15));
      chk("holdspeed", spd, fq(15));
    end
    idle();
  endtask
  task automatic resume(logic [2:0] m, logic [3:0] s);
    mode = m;
    run = 1'b1;
    wait_stage(4'hF, cyc);
    wait_stage(4'h0, cyc);
    chk("loop", 16'(auto), 16'h0001);
    chk("notdone", 16'(done), 16'h0000);
    wait_stage(4'h3, cyc);
    run = 1'b0;
    repeat (2) @(negedge clk);
    chk("haltdir", 16'(dir), 16'h0000);
    run = 1'b1;
    repeat (2) @(negedge clk);
    chk("restage", 16'(stg), 16'(s));
    chk("respeed", fref, fq(s));
    idle();
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    {run, wob, pid} = 3'h0;
    mode = 3'h0;
    nfreq = 16'h1000;
    ndir = 2'h2;
    nacc = 16'h0033;
    s0f = fq(0);
    for (int n = 0; n < 16; n++)
    begin
      if (n > 0) sf[16 * (n - 1) +: 16] = fq(n);
      st[16 * n +: 16] = tm(n);
      sd[2 * n +: 2] = dr(n);
    end
    rows = '{'{3'h0, 0, 0, 0, 0}, '{3'h7, 0, 0, 0, 0}, '{3'h4, 1, 0, 0, 0},
      '{3'h2, 0, 1, 0, 0}, '{3'h1, 0, 0, 1, 0}, '{3'h5, 0, 0, 0, 1}};
    repeat (11) @(negedge clk);
    chk("rstfreq", fref, 16'h0000);
    chk("rstmsel", 16'(msen), 16'h0001);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    st_keep = st;
    foreach (rows[i])
    begin
      {mode, wob, pid, run} = {rows[i].m, rows[i].w, rows[i].p, 1'b1};
      nfreq = 16'h1000 + 16'(i);
      ndir = 2'((i % 2) + 1);
      nacc = 16'h0033 + 16'(i);
      st = rows[i].z ? '0 : st_keep;
      repeat (3) @(negedge clk);
      chk("auto", 16'(auto), 16'(rows[i].a));
      chk("msel", 16'(msen), 16'(!rows[i].a));
      chk("rowfreq", fref, rows[i].a ? fq(0) : nfreq);
      chk("rowacc", acc, rows[i].a ? 16'h0011 : nacc);
      chk("rowdir", 16'(dir), rows[i].a ? 16'(dr(0)) : 16'(ndir));
      {wob, pid} = 2'h0;
      st = st_keep;
      idle();
    end
    // Out-of-range stage 0 frequency and direction code 3
    s0f = 16'hFFFF;
    sd[1:0] = 2'h3;
    {mode, run} = {3'h4, 1'b1};
    repeat (2) @(negedge clk);
    chk("clampfreq", fref, asps_pkg::FREQ_MAX);
    chk("dir3", 16'(dir), 16'h0000);
    s0f = fq(0);
    sd[1:0] = dr(0);
    idle();
    run_pass(3'h1);
    run_pass(3'h4);
    run_pass(3'h3);
    run_pass(3'h6);
    resume(3'h2, 4'h3);
    resume(3'h5, 4'h0);
    report_and_stop;
  end
endmodule
